// [rtl/aic_consts.vh]
// Constants shared by the analog input conditioning design files.
`ifndef AIC_CONSTS_VH
`define AIC_CONSTS_VH

// Register byte offsets; per-channel registers step by one word.
`define AIC_OFS_CTRL 8'h00
`define AIC_OFS_FUNC 8'h04
`define AIC_OFS_SIGTYPE 8'h08
`define AIC_OFS_REFSEL 8'h0C
`define AIC_OFS_SPEED 8'h10
`define AIC_OFS_GAIN0 8'h14
`define AIC_OFS_OFFSET0 8'h20
`define AIC_OFS_FILTER0 8'h2C
`define AIC_OFS_VALUE0 8'h40
`define AIC_OFS_SPDREF 8'h4C

// Field positions.
`define AIC_CTRL_DZ 0
`define AIC_CTRL_REMOTE 1
`define AIC_FIELD_STEP 4
`define AIC_REF_REMOTE_LSB 4
`define AIC_REF_COMBINE_LSB 8

// Reset values.
`define AIC_FUNC_RST 12'h085
`define AIC_SIGTYPE_RST 12'h000
`define AIC_GAIN_RST 14'h03E8
`define AIC_MIN_SPD_RST 16'h0000
`define AIC_MAX_SPD_RST 16'h0708

// Function and signal-type codes.
`define AIC_FN_SPEED 4'h0
`define AIC_FN_USER 4'h3
`define AIC_FN_THERM 4'h4
`define AIC_FN_PID1 4'h5
`define AIC_FN_PID2 4'h6
`define AIC_FN_EXTPID 4'h8
`define AIC_SIG_DIRECT 3'h0
`define AIC_SIG_LIVE 3'h1
`define AIC_SIG_INV 3'h2
`define AIC_SIG_LIVE_INV 3'h3
`define AIC_SIG_BIPOLAR 3'h4

// Scaling: converter codes are 12 bits, percent is held in 0.1 % units.
`define AIC_CODE_4MA 13'h0333
`define AIC_CODE_MID 13'h0800
`define AIC_K_FULL 17'h03E85
`define AIC_K_LIVE 17'h04E25
`define AIC_K_BIP 17'h07D0A
`define AIC_K_DIV1000 12'h419
`define AIC_PCT_FULL 12'h3E8

// Filter timing: time constant step of 10 ms, 8 ns clock, 1/64 update weight.
`define AIC_TC_UNIT_NS 10000000
`define AIC_CLK_NS 8
`define AIC_FILT_SHIFT 6
`define AIC_FILT_UNIT_CYC (`AIC_TC_UNIT_NS / (`AIC_CLK_NS * (1 << `AIC_FILT_SHIFT)))

`endif

// [rtl/aic_filter.v]
// First-order low-pass filter of one conditioned analog input.
`timescale 1ns/1ns
`default_nettype none
`include "aic_consts.vh"

module aic_filter #(
  parameter [14:0] UNIT_CYC = 15'h4C4B
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire signed [11:0] x,
  input wire [10:0] tc,
  output wire signed [11:0] y
);

  reg [25:0] cnt;
  reg signed [17:0] acc;
  wire [25:0] limit;
  wire signed [17:0] x_ext;

  // The weight is fixed at 1/64, so the update period scales with the time
  // constant; this avoids a divider at the cost of coarse steps at large tc.
  assign limit = tc * UNIT_CYC;
  assign x_ext = {{6{x[11]}}, x};
  assign y = acc[17:6];

  // Accumulator holds 64 times the output; zero time constant bypasses it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 26'h0000000;
      acc <= 18'h00000;
    end else if (ce) begin
      if (tc == 11'h000) begin
        cnt <= 26'h0000000;
        acc <= {x, 6'h00};
      end else if (cnt >= limit - 26'h0000001) begin
        cnt <= 26'h0000000;
        acc <= acc + x_ext - (acc >>> `AIC_FILT_SHIFT);
      end else begin
        cnt <= cnt + 26'h0000001;
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/aic_scale.v]
// Signal-type scaling, offset, gain and saturation of one analog input.
`timescale 1ns/1ns
`default_nettype none
`include "aic_consts.vh"

module aic_scale #(
  parameter BIPOLAR = 0
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire load,
  input wire [11:0] code,
  input wire [2:0] sig_type,
  input wire signed [10:0] offset,
  input wire [13:0] gain,
  output reg signed [11:0] pct
);

  reg signed [13:0] diff;
  reg signed [17:0] k;
  reg signed [31:0] prod;
  reg signed [16:0] sum;
  reg signed [31:0] scaled;
  reg signed [44:0] div;
  reg signed [25:0] result;
  reg inv;
  reg signed [11:0] next_pct;

  // Scale by span, add offset, multiply by gain, then invert if asked.
  always @* begin
    diff = $signed({2'b00, code});
    k = $signed({1'b0, `AIC_K_FULL});
    inv = 1'b0;
    case (sig_type)
      `AIC_SIG_LIVE, `AIC_SIG_LIVE_INV: begin
        diff = $signed({2'b00, code}) - $signed({1'b0, `AIC_CODE_4MA});
        k = $signed({1'b0, `AIC_K_LIVE});
      end
      `AIC_SIG_BIPOLAR: begin
        if (BIPOLAR != 0) begin
          diff = $signed({2'b00, code}) - $signed({1'b0, `AIC_CODE_MID});
          k = $signed({1'b0, `AIC_K_BIP});
        end
      end
      default: begin
        diff = $signed({2'b00, code});
      end
    endcase
    inv = (sig_type == `AIC_SIG_INV) || (sig_type == `AIC_SIG_LIVE_INV);
    prod = diff * k;
    sum = $signed({prod[31], prod[31:16]}) + $signed({{6{offset[10]}}, offset});
    scaled = sum * $signed({1'b0, gain});
    div = scaled * $signed({1'b0, `AIC_K_DIV1000});
    result = {div[44], div[44:20]};
    if (inv) begin
      result = $signed({14'h0000, `AIC_PCT_FULL}) - result;
    end
    // Saturate to plus or minus 100.0 %.
    if (result > $signed({14'h0000, `AIC_PCT_FULL})) begin
      next_pct = $signed(`AIC_PCT_FULL);
    end else if (result < -$signed({14'h0000, `AIC_PCT_FULL})) begin
      next_pct = -$signed(`AIC_PCT_FULL);
    end else begin
      next_pct = result[11:0];
    end
  end

  // The converted value is held until the next sample arrives.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pct <= 12'h000;
    end else if (ce && load) begin
      pct <= next_pct;
    end
  end

endmodule
`default_nettype wire

// [rtl/aic_top.v]
// Analog input conditioning: APB registers, three input channels, routing.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "aic_consts.vh"

module aic_top #(
  parameter integer FILT_UNIT_CYC = `AIC_FILT_UNIT_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sample_valid,
  input wire [11:0] sample_one,
  input wire [11:0] sample_two,
  input wire [11:0] sample_three,
  output reg [11:0] in_one_value,
  output reg [11:0] in_two_value,
  output reg [11:0] in_three_value,
  output reg [15:0] speed_ref_rpm,
  output reg speed_ref_reverse,
  output reg speed_ref_active,
  output reg [11:0] user_prog_one,
  output reg [11:0] user_prog_two,
  output reg [11:0] user_prog_three,
  output reg [2:0] user_prog_valid,
  output reg [11:0] therm_value,
  output reg therm_valid,
  output reg [11:0] pid_fb_one,
  output reg pid_fb_one_valid,
  output reg [11:0] pid_fb_two,
  output reg pid_fb_two_valid,
  output reg [11:0] ext_pid_fb,
  output reg ext_pid_fb_valid,
  output reg [1:0] pid_feedback_combine
);

  // Configuration registers.
  reg dead_zone_enable;
  reg remote_select;
  reg [11:0] function_sel;
  reg [11:0] signal_type;
  reg [1:0] local_ref_source_sel;
  reg [1:0] remote_ref_source_sel;
  reg [15:0] minimum_speed;
  reg [15:0] maximum_speed;
  reg [13:0] gain [0:2];
  reg [10:0] offset [0:2];
  reg [10:0] filter_tc [0:2];

  wire [11:0] samp [0:2];
  wire [11:0] scaled [0:2];
  wire [11:0] filt [0:2];

  assign samp[0] = sample_one;
  assign samp[1] = sample_two;
  assign samp[2] = sample_three;

  // One processing chain per input; only the third may run bipolar.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
      aic_scale #(
        .BIPOLAR(gi == 2)
      ) u_scale (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .load(sample_valid),
        .code(samp[gi]),
        .sig_type(signal_type[gi*`AIC_FIELD_STEP +: 3]),
        .offset(offset[gi]),
        .gain(gain[gi]),
        .pct(scaled[gi])
      );
      aic_filter #(
        .UNIT_CYC(FILT_UNIT_CYC[14:0])
      ) u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .x(scaled[gi]),
        .tc(filter_tc[gi]),
        .y(filt[gi])
      );
    end
  endgenerate

  // APB access decode. An access whose setup cycle has ce high takes one wait-free access phase.
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready && pwrite;
  wire [5:0] word = paddr[7:2];
  reg [31:0] next_rdata;
  reg next_err;
  integer ri;

  // Read mux, evaluated in the setup cycle and held for the access phase.
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
      `AIC_OFS_CTRL: next_rdata = {30'h00000000, remote_select, dead_zone_enable};
      `AIC_OFS_FUNC: next_rdata = {20'h00000, function_sel};
      `AIC_OFS_SIGTYPE: next_rdata = {20'h00000, signal_type};
      `AIC_OFS_REFSEL: next_rdata = {22'h000000, pid_feedback_combine, 2'h0,
                                     remote_ref_source_sel, 2'h0, local_ref_source_sel};
      `AIC_OFS_SPEED: next_rdata = {maximum_speed, minimum_speed};
      `AIC_OFS_SPDREF: next_rdata = {14'h0000, speed_ref_active, speed_ref_reverse,
                                     speed_ref_rpm};
      default: begin
        next_err = 1'b1;
        for (ri = 0; ri < 3; ri = ri + 1) begin
          if (word == `AIC_OFS_GAIN0 / 4 + ri) begin
            next_rdata = {18'h00000, gain[ri]};
            next_err = 1'b0;
          end
          if (word == `AIC_OFS_OFFSET0 / 4 + ri) begin
            next_rdata = {{21{offset[ri][10]}}, offset[ri]};
            next_err = 1'b0;
          end
          if (word == `AIC_OFS_FILTER0 / 4 + ri) begin
            next_rdata = {21'h000000, filter_tc[ri]};
            next_err = 1'b0;
          end
          if (word == `AIC_OFS_VALUE0 / 4 + ri) begin
            next_rdata = {{20{filt[ri][11]}}, filt[ri]};
            next_err = 1'b0;
          end
        end
        if (paddr[1:0] != 2'h0) begin
          next_err = 1'b1;
        end
      end
    endcase
  end

  // Bus answer registers; pready rises in the cycle after setup.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Register writes land at the access edge; values are read-only.
  integer wi;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_zone_enable <= 1'b0;
      remote_select <= 1'b0;
      function_sel <= `AIC_FUNC_RST;
      signal_type <= `AIC_SIGTYPE_RST;
      local_ref_source_sel <= 2'h0;
      remote_ref_source_sel <= 2'h0;
      pid_feedback_combine <= 2'h0;
      minimum_speed <= `AIC_MIN_SPD_RST;
      maximum_speed <= `AIC_MAX_SPD_RST;
      for (wi = 0; wi < 3; wi = wi + 1) begin
        gain[wi] <= `AIC_GAIN_RST;
        offset[wi] <= 11'h000;
        filter_tc[wi] <= 11'h000;
      end
    end else if (ce && wr_en && !pslverr) begin
      case (paddr)
        `AIC_OFS_CTRL: begin
          dead_zone_enable <= pwdata[`AIC_CTRL_DZ];
          remote_select <= pwdata[`AIC_CTRL_REMOTE];
        end
        `AIC_OFS_FUNC: function_sel <= pwdata[11:0];
        `AIC_OFS_SIGTYPE: signal_type <= pwdata[11:0];
        `AIC_OFS_REFSEL: begin
          local_ref_source_sel <= pwdata[1:0];
          remote_ref_source_sel <= pwdata[`AIC_REF_REMOTE_LSB +: 2];
          pid_feedback_combine <= pwdata[`AIC_REF_COMBINE_LSB +: 2];
        end
        `AIC_OFS_SPEED: begin
          minimum_speed <= pwdata[15:0];
          maximum_speed <= pwdata[31:16];
        end
        default: begin
          for (wi = 0; wi < 3; wi = wi + 1) begin
            if (word == `AIC_OFS_GAIN0 / 4 + wi) begin
              gain[wi] <= pwdata[13:0];
            end
            if (word == `AIC_OFS_OFFSET0 / 4 + wi) begin
              offset[wi] <= pwdata[10:0];
            end
            if (word == `AIC_OFS_FILTER0 / 4 + wi) begin
              filter_tc[wi] <= pwdata[10:0];
            end
          end
        end
      endcase
    end
  end

  // Speed reference: selected source, magnitude, dead zone and limits.
  wire [1:0] src = remote_select ? remote_ref_source_sel : local_ref_source_sel;
  wire [1:0] src_idx = src - 2'h1;
  wire [11:0] src_val = filt[src_idx];
  wire [3:0] src_fn = function_sel[src_idx*`AIC_FIELD_STEP +: 4];
  wire next_spd_active = (src != 2'h0) && (src_fn == `AIC_FN_SPEED);
  wire src_neg = src_val[11];
  wire [11:0] src_neg_val = 12'h000 - src_val;
  wire [9:0] mag = src_neg ? src_neg_val[9:0] : src_val[9:0];
  wire [15:0] span_live = (maximum_speed > minimum_speed) ?
                          maximum_speed - minimum_speed : 16'h0000;
  // Dead zone scales against maximum; otherwise against the span above min.
  wire [15:0] span = dead_zone_enable ? maximum_speed : span_live;
  wire [25:0] mul = mag * span;
  wire [37:0] mul_div = mul * `AIC_K_DIV1000;
  wire [15:0] frac_spd = mul_div[35:20];
  reg [15:0] next_spd;

  // Clamp the final value to the minimum and maximum speed settings.
  always @* begin
    if (dead_zone_enable) begin
      next_spd = (frac_spd < minimum_speed) ? minimum_speed : frac_spd;
    end else begin
      next_spd = minimum_speed + frac_spd;
    end
    if (next_spd > maximum_speed) begin
      next_spd = maximum_speed;
    end
  end

  // Function routing; the loop runs from the last input so the first wins.
  reg [11:0] next_therm;
  reg next_therm_v;
  reg [11:0] next_pid1;
  reg next_pid1_v;
  reg [11:0] next_pid2;
  reg next_pid2_v;
  reg [11:0] next_ext;
  reg next_ext_v;
  reg [2:0] next_user_v;
  reg [3:0] fn;
  integer fi;
  always @* begin
    next_therm = 12'h000;
    next_therm_v = 1'b0;
    next_pid1 = 12'h000;
    next_pid1_v = 1'b0;
    next_pid2 = 12'h000;
    next_pid2_v = 1'b0;
    next_ext = 12'h000;
    next_ext_v = 1'b0;
    next_user_v = 3'h0;
    fn = 4'h0;
    for (fi = 2; fi >= 0; fi = fi - 1) begin
      fn = function_sel[fi*`AIC_FIELD_STEP +: 4];
      case (fn)
        `AIC_FN_USER: next_user_v[fi] = 1'b1;
        `AIC_FN_THERM: begin
          next_therm = filt[fi];
          next_therm_v = 1'b1;
        end
        `AIC_FN_PID1: begin
          next_pid1 = filt[fi];
          next_pid1_v = 1'b1;
        end
        `AIC_FN_PID2: begin
          next_pid2 = filt[fi];
          next_pid2_v = 1'b1;
        end
        `AIC_FN_EXTPID: begin
          next_ext = filt[fi];
          next_ext_v = 1'b1;
        end
        default: begin
          fn = fn;
        end
      endcase
    end
  end

  // Output registers; routed values carry the filtered percent.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_one_value <= 12'h000;
      in_two_value <= 12'h000;
      in_three_value <= 12'h000;
      speed_ref_rpm <= 16'h0000;
      speed_ref_reverse <= 1'b0;
      speed_ref_active <= 1'b0;
      user_prog_one <= 12'h000;
      user_prog_two <= 12'h000;
      user_prog_three <= 12'h000;
      user_prog_valid <= 3'h0;
      therm_value <= 12'h000;
      therm_valid <= 1'b0;
      pid_fb_one <= 12'h000;
      pid_fb_one_valid <= 1'b0;
      pid_fb_two <= 12'h000;
      pid_fb_two_valid <= 1'b0;
      ext_pid_fb <= 12'h000;
      ext_pid_fb_valid <= 1'b0;
    end else if (ce) begin
      in_one_value <= filt[0];
      in_two_value <= filt[1];
      in_three_value <= filt[2];
      speed_ref_active <= next_spd_active;
      speed_ref_rpm <= next_spd_active ? next_spd : 16'h0000;
      speed_ref_reverse <= next_spd_active && src_neg;
      user_prog_one <= next_user_v[0] ? filt[0] : 12'h000;
      user_prog_two <= next_user_v[1] ? filt[1] : 12'h000;
      user_prog_three <= next_user_v[2] ? filt[2] : 12'h000;
      user_prog_valid <= next_user_v;
      therm_value <= next_therm;
      therm_valid <= next_therm_v;
      pid_fb_one <= next_pid1;
      pid_fb_one_valid <= next_pid1_v;
      pid_fb_two <= next_pid2;
      pid_fb_two_valid <= next_pid2_v;
      ext_pid_fb <= next_ext;
      ext_pid_fb_valid <= next_ext_v;
    end
  end

endmodule
`default_nettype wire

// [tb/aic_adc_model.sv]
// Behavioural model of the three converters that feed the block.
`timescale 1ns/1ns
`default_nettype none
module aic_adc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic slow,
  input wire logic [11:0] code_a,
  input wire logic [11:0] code_b,
  input wire logic [11:0] code_c,
  output logic sample_valid,
  output logic [11:0] sample_one,
  output logic [11:0] sample_two,
  output logic [11:0] sample_three
);
  logic [2:0] wait_cnt;

  // A conversion ends one or five cycles after the request. Outside the strobe the codes
  // toggle every cycle, so a block that latches them at the wrong edge takes garbage.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 3'h0;
      sample_valid <= 1'b0;
      sample_one <= 12'h000;
      sample_two <= 12'h000;
      sample_three <= 12'h000;
    end else begin
      wait_cnt <= req ? (slow ? 3'h5 : 3'h1) : (wait_cnt != 3'h0 ? wait_cnt - 3'h1 : 3'h0);
      sample_valid <= (wait_cnt == 3'h1);
      sample_one <= (wait_cnt == 3'h1) ? code_a : ~sample_one;
      sample_two <= (wait_cnt == 3'h1) ? code_b : ~sample_two;
      sample_three <= (wait_cnt == 3'h1) ? code_c : ~sample_three;
    end
  end
endmodule
`default_nettype wire

// [tb/aic_props.sv]
// Port checker of the analog input conditioning block, with its bind.
`timescale 1ns/1ns
`default_nettype none
module aic_props #(
  parameter integer FILT_UNIT_CYC = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] in_one_value,
  input wire logic [11:0] in_two_value,
  input wire logic [11:0] in_three_value,
  input wire logic [15:0] speed_ref_rpm,
  input wire logic speed_ref_active,
  input wire logic [11:0] user_prog_three,
  input wire logic [2:0] user_prog_valid,
  input wire logic [11:0] pid_fb_one,
  input wire logic pid_fb_one_valid,
  input wire logic [1:0] pid_feedback_combine
);
  // Everything runs on the bus clock and sleeps through reset.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only a completed write may move a configuration output.
  wire wr_done = psel && penable && pwrite && pready;

  chk_setup_answer: assert property (psel && !penable && ce |=> pready)
    else $error("no answer one cycle after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  chk_misaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  chk_value_range: assert property (
    $signed(in_one_value) >= -1000 && $signed(in_one_value) <= 1000 &&
    $signed(in_two_value) >= -1000 && $signed(in_two_value) <= 1000 &&
    $signed(in_three_value) >= -1000 && $signed(in_three_value) <= 1000)
    else $error("percent value outside full scale");
  chk_user_only: assert property (
    user_prog_three == (user_prog_valid[2] ? in_three_value : 12'h000))
    else $error("user program output not gated by its function");
  chk_speed_idle: assert property (!speed_ref_active |-> speed_ref_rpm == 16'h0000)
    else $error("speed reference without selected source");
  chk_pid_source: assert property (pid_fb_one_valid |->
    pid_fb_one == in_one_value || pid_fb_one == in_two_value || pid_fb_one == in_three_value)
    else $error("feedback one not taken from an input");
  chk_combine_hold: assert property (
    $changed(pid_feedback_combine) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("combine setting moved without a write");
endmodule

bind aic_top aic_props #(.FILT_UNIT_CYC(FILT_UNIT_CYC)) u_props (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .in_one_value, .in_two_value, .in_three_value, .speed_ref_rpm, .speed_ref_active,
  .user_prog_three, .user_prog_valid, .pid_fb_one, .pid_fb_one_valid, .pid_feedback_combine
);
`default_nettype wire

// [tb/test_analog_input_conditioning.sv]
// Self-checking testbench of the analog input conditioning block.
`timescale 1ns/1ns
`default_nettype none
`include "aic_consts.vh"
module test_analog_input_conditioning;
  typedef struct {bit wr; logic [31:0] e; int tol; bit err;} aic_exp_t;
  localparam int UNIT = 2;
  localparam int TAU = 64 * UNIT;
  localparam int MN = 300;
  localparam int MX = 1800;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req, slow, sample_valid, ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] code_a, code_b, code_c, sample_one, sample_two, sample_three;
  logic [11:0] pid_fb_one, therm_value;
  logic [2:0] user_prog_valid;
  logic pid_fb_one_valid, pid_fb_two_valid, ext_pid_fb_valid;
  aic_exp_t q[$];
  aic_exp_t x;
  int bad_count, checked, seed, i, d;

  aic_top #(.FILT_UNIT_CYC(UNIT)) dut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sample_valid, .sample_one, .sample_two, .sample_three,
    .in_one_value(), .in_two_value(), .in_three_value(), .speed_ref_rpm(),
    .speed_ref_reverse(), .speed_ref_active(), .user_prog_one(), .user_prog_two(),
    .user_prog_three(), .user_prog_valid, .therm_value, .therm_valid(),
    .pid_fb_one, .pid_fb_one_valid, .pid_fb_two(), .pid_fb_two_valid,
    .ext_pid_fb(), .ext_pid_fb_valid, .pid_feedback_combine()
  );

  aic_adc_model adc (
    .pclk, .presetn, .req, .slow, .code_a, .code_b, .code_c, .sample_valid,
    .sample_one, .sample_two, .sample_three
  );

  // Free-running 125 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // The whole run needs a few thousand cycles; twenty thousand means a hang.
  initial begin
    #160000;
    bad_count++;
    finish_test;
  end

  task automatic finish_test;
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Each bus answer is judged against the oldest note left by the driver.
  always @(posedge pclk) begin
    if (pready === 1'b1 && q.size() > 0) begin
      x = q.pop_front();
      d = $signed(prdata) - $signed(x.e);
      d = (d < 0) ? -d : d;
      checked++;
      if (pslverr !== x.err || (!x.wr && (^prdata === 1'bx || d > x.tol))) begin
        bad_count++;
        $display("MISMATCH reg %h expected %h/%0d seen %h/%b", paddr, x.e, x.err, prdata, pslverr);
      end
    end
  end

  // One transfer; the request is held until pready is sampled high.
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] dat,
                     input logic [31:0] e, input int tol, input bit err);
    int n;
    begin
      q.push_back('{w, e, tol, err});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) bad_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, 32'h0, 0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input int tol);
    apb(1'b0, a, 32'h0, e, tol, 1'b0);
  endtask

  // A routed level output against its expectation; unknown bits count as a miss.
  task automatic look(input string n, input logic signed [15:0] e, s, input int tol);
    begin
      checked++;
      if (^s === 1'bx || s - e > tol || e - s > tol) begin
        bad_count++;
        $display("MISMATCH %s expected %0d seen %0d", n, e, s);
      end
    end
  endtask

  // Converter request; twelve cycles cover the slow conversion plus three pipeline edges.
  task automatic sample(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c,
                        input bit s);
    begin
      code_a <= a;
      code_b <= b;
      code_c <= c;
      slow <= s;
      req <= 1'b1;
      @(posedge pclk);
      req <= 1'b0;
      repeat (12) @(posedge pclk);
    end
  endtask

  // Ideal percent in 0.1 % units; the bench tolerance absorbs the fixed-point rounding.
  function automatic int pct(input int t, input int c, input int off, input int g);
    real b;
    begin
      if (t == 1 || t == 3) b = (c * 20.0 / 4095.0 - 4.0) / 16.0 * 1000.0;
      else if (t == 4) b = (c - 2048) / 2048.0 * 1000.0;
      else b = c / 4095.0 * 1000.0;
      b = (b + off) * g / 1000.0;
      if (t == 2 || t == 3) b = 1000.0 - b;
      if (b > 1000.0) b = 1000.0;
      if (b < -1000.0) b = -1000.0;
      return int'(b);
    end
  endfunction

  function automatic logic [31:0] spd(input int v, input bit dz);
    real a, r;
    logic [15:0] rpm;
    begin
      a = (v < 0) ? -v : v;
      r = dz ? a * MX / 1000.0 : MN + a * (MX - MN) / 1000.0;
      if (r < MN) r = MN;
      if (r > MX) r = MX;
      rpm = 16'(int'(r));
      return {14'h0000, 1'b1, v < 0, rpm};
    end
  endfunction

  task automatic scale(input int t, input int c, input int off, input int g);
    begin
      wr(`AIC_OFS_SIGTYPE, t);
      wr(`AIC_OFS_OFFSET0, off);
      wr(`AIC_OFS_GAIN0, g);
      sample(c[11:0], 12'h000, 12'h000, c[0]);
      rd(`AIC_OFS_VALUE0, pct(t, c, off, g), 3);
    end
  endtask

  task automatic speed(input bit dz, input int t, input int c, input int off);
    begin
      wr(`AIC_OFS_CTRL, {31'h0, dz});
      wr(`AIC_OFS_SIGTYPE, t << 8);
      wr(`AIC_OFS_OFFSET0 + 8'h08, off);
      sample(12'h000, 12'h000, c[11:0], 1'b0);
      rd(`AIC_OFS_SPDREF, spd(pct(t, c, off, 1000), dz), 6);
    end
  endtask

  initial begin
    seed = 41323;
    bad_count = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = 1'b0;
    slow = 1'b0;
    ce = 1'b1;
    code_a = 12'h000;
    code_b = 12'h000;
    code_c = 12'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset contents, refused accesses and a read-only register.
    rd(`AIC_OFS_FUNC, 32'h085, 0);
    rd(`AIC_OFS_GAIN0, 32'h3E8, 0);
    rd(`AIC_OFS_SPEED, {`AIC_MAX_SPD_RST, `AIC_MIN_SPD_RST}, 0);
    apb(1'b0, 8'h50, 32'h0, 32'h0, 0, 1'b1);
    apb(1'b1, 8'h06, 32'h1, 32'h0, 0, 1'b1);
    wr(`AIC_OFS_VALUE0, 32'h123);
    rd(`AIC_OFS_VALUE0, 32'h0, 0);
    // First input: corner cases of signal types 0 to 3, then random settings.
    scale(0, 4095, 0, 2000);
    scale(2, 0, 0, 1000);
    scale(3, 4095, 0, 1000);
    scale(0, 2048, -700, 1000);
    scale(1, 2457, -800, 1000);
    // Clock enable low: a conversion that arrives meanwhile must leave no trace.
    ce <= 1'b0;
    sample(12'hFFF, 12'hFFF, 12'hFFF, 1'b0);
    ce <= 1'b1;
    rd(`AIC_OFS_VALUE0, pct(1, 2457, -800, 1000), 3);
    for (i = 0; i < 8; i++) begin
      scale($random(seed) & 3, $random(seed) & 4095, $random(seed) % 200,
            500 + ($random(seed) & 1023));
    end
    // Filter of one time-constant unit: a step is far off at once, near after three.
    wr(`AIC_OFS_SIGTYPE, 32'h0);
    wr(`AIC_OFS_OFFSET0, 32'h0);
    wr(`AIC_OFS_GAIN0, 32'h3E8);
    wr(`AIC_OFS_FILTER0, 32'h1);
    sample(12'h000, 12'h000, 12'h000, 1'b0);
    repeat (6 * TAU) @(posedge pclk);
    sample(12'hFFF, 12'h000, 12'h000, 1'b0);
    rd(`AIC_OFS_VALUE0, 32'h4B, 75);
    repeat (3 * TAU) @(posedge pclk);
    rd(`AIC_OFS_VALUE0, 32'h3BB, 45);
    wr(`AIC_OFS_FILTER0, 32'h0);
    // Speed reference from the third input, dead zone off and on, both directions.
    wr(`AIC_OFS_SPEED, 32'h0708012C);
    wr(`AIC_OFS_REFSEL, 32'h203);
    speed(0, 0, 0, 0);
    speed(1, 0, 400, 0);
    speed(1, 0, 2048, 0);
    speed(0, 0, 2048, -700);
    speed(0, 4, 0, 0);
    speed(1, 4, 3072, 0);
    // No source selected; shared feedback function and user program routing.
    wr(`AIC_OFS_REFSEL, 32'h100);
    wr(`AIC_OFS_FUNC, 32'h355);
    sample(12'h123, 12'h456, 12'h789, 1'b1);
    rd(`AIC_OFS_SPDREF, 32'h0, 0);
    look("pid one", pct(0, 291, 0, 1000), $signed(pid_fb_one), 3);
    look("pid one valid", 1, pid_fb_one_valid, 0);
    look("user valid", 4, user_prog_valid, 0);
    // Thermistor on the second input; its current source lives outside this block.
    wr(`AIC_OFS_FUNC, 32'h048);
    repeat (2) @(posedge pclk);
    look("therm", pct(0, 1110, 0, 1000), $signed(therm_value), 3);
    look("ext valid", 1, ext_pid_fb_valid, 0);
    look("pid two valid", 0, pid_fb_two_valid, 0);
    finish_test;
  end
endmodule
`default_nettype wire
